// ### design/cmd_pkg.sv
// Purpose: shared constants for the maintenance command slice
// Assumes: 250 MHz system clock
// Notes: times kept in ms, cycle counts derived
package cmd_pkg;
  localparam logic [15:0] CMD_FACTORY_RESTORE = 16'h3632;
  localparam logic [15:0] CMD_REINIT = 16'h3646;
  localparam logic [7:0] checksum_generator_poly = 8'h31;
  localparam logic [7:0] checksum_preset_value = 8'hFF;
  localparam logic [7:0] CHECKSUM_FINAL_XOR = 8'h00;
  localparam int CLK_MHZ = 250;
  localparam int RESTORE_MS = 1200;
  localparam int REINIT_MS = 20;
  // cycle counts are exact; the longest still fits TIMER_W
  localparam longint RESTORE_CYCLES = longint'(RESTORE_MS) * 1000 * CLK_MHZ;
  localparam longint REINIT_CYCLES = longint'(REINIT_MS) * 1000 * CLK_MHZ;
  localparam int TIMER_W = 32;
endpackage

// ### design/checksum_unit.sv
// Purpose: 8-bit checksum over one 16-bit word
// Assumes: word given with high byte first on the link
// Notes: purely combinational
`timescale 1ns/1ps
module checksum_unit (
  // data word
  input wire logic [15:0] WORD,
  // checksum
  output logic [7:0] SUM
);
  function automatic logic [7:0] mix_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ cmd_pkg::checksum_generator_poly;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // only the two bytes of this word are covered
  always_comb begin
    SUM = mix_byte(mix_byte(cmd_pkg::checksum_preset_value, WORD[15:8]), WORD[7:0])
          ^ cmd_pkg::CHECKSUM_FINAL_XOR;
  end
endmodule

// ### design/maint_cmd.sv
// Purpose: factory restore and re-init command execution with word checksums
// Assumes: byte framing of the link done upstream; inputs synchronous to CLK_SYS
// Notes: nonvolatile store reached through clear/reload strobes
`timescale 1ns/1ps
module maint_cmd #(
  parameter longint RESTORE_CYCLES = cmd_pkg::RESTORE_CYCLES,
  parameter longint REINIT_CYCLES = cmd_pkg::REINIT_CYCLES
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // command word from the link
  input wire logic CMD_VALID,
  input wire logic [15:0] CMD_WORD,
  // written data word with checksum
  input wire logic WDATA_VALID,
  input wire logic [15:0] WDATA_WORD,
  input wire logic [7:0] WDATA_SUM,
  // read data word to send
  input wire logic RDATA_VALID,
  input wire logic [15:0] RDATA_WORD,
  output logic RDATA_OUT_VALID,
  output logic [15:0] RDATA_OUT_WORD,
  output logic [7:0] RDATA_OUT_SUM,
  // measurement state
  input wire logic MEAS_RUNNING,
  // nonvolatile store control
  output logic NV_CLEAR,
  output logic CAL_ERASE,
  output logic NV_RELOAD,
  // status
  output logic BUSY,
  output logic CMD_DONE,
  output logic WDATA_ERROR,
  output logic CMD_REJECTED
);
  typedef enum {IDLE, RESTORE, REINIT} state_type;

  state_type state;
  state_type next_state;
  logic [cmd_pkg::TIMER_W-1:0] timer;
  logic [cmd_pkg::TIMER_W-1:0] next_timer;
  logic [7:0] wsum;
  logic [7:0] rsum;
  logic wdata_bad;
  logic cmd_take;
  logic start_restore;
  logic start_reinit;
  logic refuse;
  logic timer_zero;

  ////////////////////////////////////////////////////////////////////////////
  // command code decode
  function automatic logic is_restore(input logic [15:0] code);
    return code == cmd_pkg::CMD_FACTORY_RESTORE;
  endfunction

  function automatic logic is_reinit(input logic [15:0] code);
    return code == cmd_pkg::CMD_REINIT;
  endfunction

  // the timer counts down to zero; the zero cycle is the last busy one
  function automatic logic [cmd_pkg::TIMER_W-1:0] load_count(input longint cycles);
    longint last;
    last = cycles - longint'(1);
    return last[cmd_pkg::TIMER_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  checksum_unit write_check (
    .WORD(WDATA_WORD),
    .SUM(wsum)
  );

  checksum_unit read_gen (
    .WORD(RDATA_WORD),
    .SUM(rsum)
  );

  assign wdata_bad = WDATA_VALID && (WDATA_SUM != wsum);

  ////////////////////////////////////////////////////////////////////////////
  // command acceptance; command words are decoded without a checksum byte
  assign cmd_take = CMD_VALID && (state == IDLE);
  assign start_restore = cmd_take && !wdata_bad && is_restore(CMD_WORD);
  assign start_reinit = cmd_take && !wdata_bad && is_reinit(CMD_WORD) && !MEAS_RUNNING;
  // bad data in the same cycle, or re-init while measuring, refuses the command
  assign refuse = cmd_take && (wdata_bad || (is_reinit(CMD_WORD) && MEAS_RUNNING));
  assign timer_zero = (timer == '0);

  ////////////////////////////////////////////////////////////////////////////
  // next state and timer
  always_comb begin
    next_state = state;
    next_timer = timer;
    case (state)
      IDLE: begin
        if (start_restore) begin
          next_state = RESTORE;
          next_timer = load_count(RESTORE_CYCLES);
        end else if (start_reinit) begin
          next_state = REINIT;
          next_timer = load_count(REINIT_CYCLES);
        end
      end
      RESTORE, REINIT: begin
        // further commands ignored until the duration ends
        if (timer_zero) begin
          next_state = IDLE;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      timer <= '0;
    end else begin
      timer <= next_timer;
    end
  end

  assign BUSY = (state != IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile store strobes, one cycle each
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      NV_CLEAR <= 1'b0;
      CAL_ERASE <= 1'b0;
      NV_RELOAD <= 1'b0;
    end else begin
      NV_CLEAR <= start_restore;
      CAL_ERASE <= start_restore;
      NV_RELOAD <= start_reinit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion pulse in the first idle cycle after the busy state
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CMD_DONE <= 1'b0;
    end else begin
      CMD_DONE <= (state != IDLE) && timer_zero;
    end
  end

  // refusal pulse; commands dropped while busy raise nothing
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CMD_REJECTED <= 1'b0;
    end else begin
      CMD_REJECTED <= refuse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write data error flag, one cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      WDATA_ERROR <= 1'b0;
    end else begin
      WDATA_ERROR <= wdata_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data word leaves with its checksum appended
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RDATA_OUT_VALID <= 1'b0;
    end else begin
      RDATA_OUT_VALID <= RDATA_VALID;
    end
  end

  // word and checksum hold until the next word is handed over
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RDATA_OUT_WORD <= 16'h0000;
      RDATA_OUT_SUM <= 8'h00;
    end else begin
      if (RDATA_VALID) begin
        RDATA_OUT_WORD <= RDATA_WORD;
        RDATA_OUT_SUM <= rsum;
      end
    end
  end
endmodule

// ### bench/host_model.sv
// Purpose: host model
// Assumes: falling-edge drive
// Notes: data word 16'hBEEF
`timescale 1ns/1ps
module host_model (
  // link
  input wire logic CLK_SYS,
  output logic CMD_VALID, WDATA_VALID, MEAS_RUNNING,
  output logic [15:0] CMD_WORD, WDATA_WORD,
  output logic [7:0] WDATA_SUM
);
  initial {CMD_VALID, CMD_WORD, WDATA_VALID, WDATA_WORD, WDATA_SUM, MEAS_RUNNING} = 43'h0;
  task automatic send(input logic [15:0] c, input logic d, bad);
    @(negedge CLK_SYS);
    {CMD_VALID, CMD_WORD, WDATA_VALID, WDATA_WORD} = {1'b1, c, d, 16'hBEEF};
    WDATA_SUM = 8'h92 ^ {7'h00, bad};
    @(negedge CLK_SYS);
    {CMD_VALID, WDATA_VALID, WDATA_WORD} = {2'b00, 16'h4110};
  endtask
endmodule

// ### bench/maint_cmd_assertions.sv
// Purpose: port checks
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
module maint_cmd_assertions #(
  parameter longint RESTORE_CYCLES = cmd_pkg::RESTORE_CYCLES,
  parameter longint REINIT_CYCLES = cmd_pkg::REINIT_CYCLES
) (
  // watched
  input wire logic CLK_SYS, RST, CMD_VALID, WDATA_VALID, RDATA_VALID, MEAS_RUNNING, NV_CLEAR, NV_RELOAD,
  input wire logic BUSY, CMD_DONE, WDATA_ERROR, CMD_REJECTED,
  input wire logic [15:0] CMD_WORD, WDATA_WORD, RDATA_WORD,
  input wire logic [7:0] WDATA_SUM, RDATA_OUT_SUM
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  int cnt;
  wire logic go = CMD_VALID && !BUSY && !WDATA_VALID;
  wire logic bad = WDATA_VALID && WDATA_WORD == 16'hBEEF && WDATA_SUM != 8'h92;
  always_ff @(posedge CLK_SYS) cnt <= (RST || !BUSY) ? 0 : cnt + 1;
  restore_a: assert property (go && CMD_WORD == 16'h3632 |=> NV_CLEAR && BUSY)
    else $error("restore");
  reinit_a: assert property (go && CMD_WORD == 16'h3646 && !MEAS_RUNNING |=> NV_RELOAD)
    else $error("reinit");
  refuse_a: assert property (go && CMD_WORD == 16'h3646 && MEAS_RUNNING |=> CMD_REJECTED)
    else $error("refuse");
  done_a: assert property (CMD_DONE |-> cnt == RESTORE_CYCLES || cnt == REINIT_CYCLES)
    else $error("done");
  read_a: assert property (RDATA_VALID && RDATA_WORD == 16'hBEEF |=> RDATA_OUT_SUM == 8'h92)
    else $error("read");
  bad_a: assert property (bad |=> WDATA_ERROR)
    else $error("flag");
  reject_a: assert property (bad && CMD_VALID && !BUSY |=> !NV_CLEAR && !NV_RELOAD)
    else $error("reject");
  busy_a: assert property (BUSY && CMD_VALID |=> !NV_CLEAR && !NV_RELOAD)
    else $error("busy");
  cover property (NV_CLEAR);
  cover property (NV_RELOAD);
  cover property (CMD_REJECTED);
endmodule
bind maint_cmd maint_cmd_assertions #(.RESTORE_CYCLES(RESTORE_CYCLES), .REINIT_CYCLES(REINIT_CYCLES)) chk (.*);

// ### bench/maint_cmd_test.sv
// Purpose: maint_cmd bench
// Assumes: counts cut to 20 and 5
// Notes: falling-edge drive
`timescale 1ns/1ps
module maint_cmd_test;
  logic CLK_SYS = 0, RST = 1, RDATA_VALID = 0;
  logic [15:0] RDATA_WORD = 0;
  wire CMD_VALID, WDATA_VALID, MEAS_RUNNING, RDATA_OUT_VALID, NV_CLEAR, CAL_ERASE, NV_RELOAD, BUSY;
  wire CMD_DONE, WDATA_ERROR, CMD_REJECTED;
  wire [15:0] CMD_WORD, WDATA_WORD, RDATA_OUT_WORD;
  wire [7:0] WDATA_SUM, RDATA_OUT_SUM;
  int bad_count = 0, n_checks = 0, cyc = 0, k;
  localparam int RESTORE_N = 20;
  localparam int REINIT_N = 5;
  always #2 CLK_SYS = ~CLK_SYS;
  host_model host (.*);
  maint_cmd #(.RESTORE_CYCLES(RESTORE_N), .REINIT_CYCLES(REINIT_N)) uut (.*);
  task automatic check(input string s, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge CLK_SYS) if (++cyc == 3000) begin
    bad_count++;
    results();
  end
  task automatic t_read(input logic [15:0] w, input logic [7:0] s);
    @(negedge CLK_SYS);
    {RDATA_VALID, RDATA_WORD} = {1'b1, w};
    @(negedge CLK_SYS);
    {RDATA_VALID, RDATA_WORD} = {1'b0, ~w};
    check("read", {1'b1, w, s}, {RDATA_OUT_VALID, RDATA_OUT_WORD, RDATA_OUT_SUM});
  endtask
  task automatic t_cmd(input logic [15:0] c, input logic m, d, input logic [5:0] e, input int n);
    host.MEAS_RUNNING = m;
    host.send(c, d, d);
    check("start", e, {NV_CLEAR, CAL_ERASE, NV_RELOAD, BUSY, CMD_REJECTED, WDATA_ERROR});
    if (n > 0) begin
      host.send(16'h3632, 0, 0);
      for (k = 0; k < 50 && CMD_DONE !== 1'b1; k++) @(negedge CLK_SYS);
      check("done", n, k);
    end
  endtask
  initial begin
    repeat (16) @(negedge CLK_SYS);
    RST = 0;
    t_read(16'hBEEF, 8'h92);
    t_read(16'h0000, 8'h81);
    t_cmd(16'h3646, 1, 0, 6'b000010, 0);
    t_cmd(16'h3632, 0, 1, 6'b000011, 0);
    // the loop starts two cycles into the busy time
    t_cmd(16'h3632, 1, 0, 6'b110100, RESTORE_N - 2);
    t_cmd(16'h3646, 0, 0, 6'b001100, REINIT_N - 2);
    results();
  end
endmodule
